// ---- hdl/hir_pkg.sv ----
// Constants, register map and state type of the host interrupt generation block.
// Assumes a single 25 MHz clock and the simple register port of hir_irq_gen.
package hir_pkg;
  localparam int CLK_NS         = 40;
  localparam int PULSE_MAX_NS   = 1000000;
  localparam int PULSE_MAX_CYC  = PULSE_MAX_NS / CLK_NS;
  localparam int TMO_UNIT_NS    = 1000000;
  localparam int TMO_UNIT_CYC   = TMO_UNIT_NS / CLK_NS;
  localparam int SPACE_UNIT_NS  = 1000;
  localparam int SPACE_UNIT_CYC = (SPACE_UNIT_NS + CLK_NS - 1) / CLK_NS;
  localparam int CAT_N          = 3;
  localparam int CAT_ISO        = 0;
  localparam int CAT_INT        = 1;
  localparam int CAT_ASYNC      = 2;
  // ---------------------------------------------------------------
  // Register byte addresses
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_MODE    = 8'h00;
  localparam logic [7:0] OFS_STATUS  = 8'h04;
  localparam logic [7:0] OFS_ENABLE  = 8'h08;
  localparam logic [7:0] OFS_PULSE   = 8'h0C;
  localparam logic [7:0] OFS_TMO     = 8'h10;
  localparam logic [7:0] OFS_DONE    = 8'h20;
  localparam logic [7:0] OFS_ANDM    = 8'h30;
  localparam logic [7:0] OFS_ORM     = 8'h40;
  localparam logic [7:0] OFS_VALID   = 8'h50;
  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int MODE_MASTER  = 0;
  localparam int MODE_TRIG    = 1;
  localparam int MODE_POL     = 2;
  localparam int STS_DMA      = 3;
  localparam int STS_CLKRDY   = 4;
  localparam int STS_ISO      = 7;
  localparam int STS_INT      = 8;
  localparam int STS_ASYNC    = 9;
  localparam int PS_WIDTH_LSB = 0;
  localparam int PS_WIDTH_W   = 16;
  localparam int PS_SPACE_LSB = 24;
  localparam int PS_SPACE_W   = 8;
  localparam int TMO_EN_BIT   = 31;
  localparam int TMO_PER_W    = 16;
  localparam logic [31:0] RST_MODE  = 32'h0000_0000;
  localparam logic [31:0] RST_PULSE = 32'h0000_0021;
  localparam logic [31:0] RST_ZERO  = 32'h0000_0000;

  typedef enum logic [1:0] {ST_IDLE, ST_PULSE, ST_SPACE} hir_state_e;
endpackage

// ---- hdl/hir_cat_eval.sv ----
// Completion evaluator for one descriptor category.
// Assumes done_map is the sticky done map and done_new marks bits set this cycle.
module hir_cat_eval #(
  parameter int DESC_N = 32
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [DESC_N-1:0] done_map,
  input  wire logic [DESC_N-1:0] done_new,
  input  wire logic [DESC_N-1:0] and_mask,
  input  wire logic [DESC_N-1:0] or_mask,
  output logic                   hit
);
  logic [DESC_N-1:0] and_eff;
  logic              and_full;
  logic              and_prev;
  logic              or_new;

  // A descriptor with its OR bit set is judged by OR alone.
  assign and_eff  = and_mask & ~or_mask;
  assign and_full = (|and_eff) && ((done_map & and_eff) == and_eff);
  assign or_new   = |(done_new & or_mask);

  always_ff @(posedge clock) begin
    if (rst) begin
      and_prev <= 1'b0;
      hit      <= 1'b0;
    end else if (ce) begin
      and_prev <= and_full;
      hit      <= or_new | (and_full & ~and_prev);
    end
  end

  a_or_raises: assert property (@(posedge clock) disable iff (rst)
    ce && (|(done_new & or_mask)) |=> hit)
    else $error("OR-mask completion not raised");

  a_and_needs_all: assert property (@(posedge clock) disable iff (rst)
    ce && !(|(done_new & or_mask)) && !and_full |=> !hit)
    else $error("AND completion raised while selection incomplete");
endmodule

// ---- hdl/hir_irq_gen.sv ----
// Interrupt generation block: sticky event status, enables, trigger shaping and
// per-category descriptor completion masks with an async list interval timer.
// Assumes all inputs are synchronous to clock, which runs independently of the
// main internal clocks that main_clk_stopped reports.
module hir_irq_gen #(
  parameter int STS_W          = 16,
  parameter int DESC_N         = 32,
  parameter int PULSE_MAX_CYC  = hir_pkg::PULSE_MAX_CYC,
  parameter int SPACE_UNIT_CYC = hir_pkg::SPACE_UNIT_CYC,
  parameter int TMO_UNIT_CYC   = hir_pkg::TMO_UNIT_CYC
) (
  input  wire logic              clock,
  input  wire logic              rst,
  input  wire logic              ce,
  input  wire logic [7:0]        reg_addr,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  input  wire logic [STS_W-1:0]  evt,
  input  wire logic              dma_done,
  input  wire logic              main_clk_stopped,
  input  wire logic [DESC_N-1:0] done_set_iso,
  input  wire logic [DESC_N-1:0] done_set_int,
  input  wire logic [DESC_N-1:0] done_set_async,
  output logic                   irq
);
  // ---------------------------------------------------------------
  // Registers and event gathering
  // ---------------------------------------------------------------
  logic [31:0]       mode_q;
  logic [STS_W-1:0]  status;
  logic [STS_W-1:0]  enable;
  logic [31:0]       pulse_q;
  logic [31:0]       tmo_q;
  logic [DESC_N-1:0] done_map [hir_pkg::CAT_N];
  logic [DESC_N-1:0] and_mask [hir_pkg::CAT_N];
  logic [DESC_N-1:0] or_mask  [hir_pkg::CAT_N];
  logic [DESC_N-1:0] valid    [hir_pkg::CAT_N];
  logic [DESC_N-1:0] done_set [hir_pkg::CAT_N];
  logic [hir_pkg::CAT_N-1:0] cat_hit;
  logic [STS_W-1:0]  set_vec;
  logic              clk_stopped_q;
  logic              async_fire;
  logic              wr_status;

  assign done_set[hir_pkg::CAT_ISO]   = done_set_iso;
  assign done_set[hir_pkg::CAT_INT]   = done_set_int;
  assign done_set[hir_pkg::CAT_ASYNC] = done_set_async;
  assign wr_status = reg_wr && (reg_addr == hir_pkg::OFS_STATUS);

  // Status is one flag per source; nothing records order or timing.
  always_comb begin
    set_vec = evt;
    set_vec[hir_pkg::STS_DMA]    = evt[hir_pkg::STS_DMA] | dma_done;
    set_vec[hir_pkg::STS_CLKRDY] = evt[hir_pkg::STS_CLKRDY]
                                   | (clk_stopped_q & ~main_clk_stopped);
    set_vec[hir_pkg::STS_ISO]    = evt[hir_pkg::STS_ISO] | cat_hit[hir_pkg::CAT_ISO];
    set_vec[hir_pkg::STS_INT]    = evt[hir_pkg::STS_INT] | cat_hit[hir_pkg::CAT_INT];
    set_vec[hir_pkg::STS_ASYNC]  = evt[hir_pkg::STS_ASYNC] | async_fire;
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      clk_stopped_q <= 1'b0;
    end else if (ce) begin
      clk_stopped_q <= main_clk_stopped;
    end
  end

  // A set arriving with its own clear wins, so no event is lost.
  always_ff @(posedge clock) begin
    if (rst) begin
      status <= hir_pkg::RST_ZERO[STS_W-1:0];
    end else if (ce) begin
      status <= (status & ~(wr_status ? reg_wdata[STS_W-1:0] : '0)) | set_vec;
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      mode_q  <= hir_pkg::RST_MODE;
      enable  <= hir_pkg::RST_ZERO[STS_W-1:0];
      pulse_q <= hir_pkg::RST_PULSE;
      tmo_q   <= hir_pkg::RST_ZERO;
    end else if (ce && reg_wr) begin
      if (reg_addr == hir_pkg::OFS_MODE) mode_q <= reg_wdata;
      if (reg_addr == hir_pkg::OFS_ENABLE) enable <= reg_wdata[STS_W-1:0];
      if (reg_addr == hir_pkg::OFS_PULSE) pulse_q <= reg_wdata;
      if (reg_addr == hir_pkg::OFS_TMO) tmo_q <= reg_wdata;
    end
  end

  // ---------------------------------------------------------------
  // Descriptor categories
  // ---------------------------------------------------------------
  for (genvar c = 0; c < hir_pkg::CAT_N; c++) begin : g_cat
    logic wr_done;
    logic wr_and;
    logic wr_or;
    logic wr_valid;
    assign wr_done  = reg_wr && (reg_addr == 8'(hir_pkg::OFS_DONE + 4 * c));
    assign wr_and   = reg_wr && (reg_addr == 8'(hir_pkg::OFS_ANDM + 4 * c));
    assign wr_or    = reg_wr && (reg_addr == 8'(hir_pkg::OFS_ORM + 4 * c));
    assign wr_valid = reg_wr && (reg_addr == 8'(hir_pkg::OFS_VALID + 4 * c));

    always_ff @(posedge clock) begin
      if (rst) begin
        done_map[c] <= '0;
        and_mask[c] <= '0;
        or_mask[c]  <= '0;
        valid[c]    <= '0;
      end else if (ce) begin
        done_map[c] <= (done_map[c] & ~(wr_done ? reg_wdata[DESC_N-1:0] : '0))
                       | done_set[c];
        if (wr_and) and_mask[c] <= reg_wdata[DESC_N-1:0];
        if (wr_or) or_mask[c] <= reg_wdata[DESC_N-1:0];
        valid[c] <= (wr_valid ? reg_wdata[DESC_N-1:0] : valid[c]) & ~done_set[c];
      end
    end

    // Each category has its own evaluator and never sees another's maps.
    hir_cat_eval #(
      .DESC_N (DESC_N)
    ) u_eval (
      .clock    (clock),
      .rst      (rst),
      .ce       (ce),
      .done_map (done_map[c] | done_set[c]),
      .done_new (done_set[c] & ~done_map[c]),
      .and_mask (and_mask[c]),
      .or_mask  (or_mask[c]),
      .hit      (cat_hit[c])
    );
  end

  // ---------------------------------------------------------------
  // Async list interval timer
  // ---------------------------------------------------------------
  localparam int TU_W = $clog2(TMO_UNIT_CYC + 1);
  logic [TU_W-1:0]              tmo_sub;
  logic [hir_pkg::TMO_PER_W-1:0] tmo_cnt;
  logic                         async_pend;
  logic                         tmo_en;
  logic                         tmo_expire;

  assign tmo_en     = tmo_q[hir_pkg::TMO_EN_BIT];
  assign tmo_expire = tmo_en && (tmo_sub == TU_W'(TMO_UNIT_CYC - 1))
                      && (tmo_cnt + 1'b1 >= tmo_q[hir_pkg::TMO_PER_W-1:0]);
  // Without the option a completion passes straight through.
  assign async_fire = tmo_en ? (tmo_expire && (async_pend || cat_hit[hir_pkg::CAT_ASYNC]))
                             : cat_hit[hir_pkg::CAT_ASYNC];

  always_ff @(posedge clock) begin
    if (rst || !tmo_en) begin
      tmo_sub    <= '0;
      tmo_cnt    <= '0;
      async_pend <= 1'b0;
    end else if (ce) begin
      if (tmo_sub == TU_W'(TMO_UNIT_CYC - 1)) begin
        tmo_sub <= '0;
        tmo_cnt <= tmo_expire ? '0 : tmo_cnt + 1'b1;
      end else begin
        tmo_sub <= tmo_sub + 1'b1;
      end
      async_pend <= tmo_expire ? 1'b0 : (async_pend | cat_hit[hir_pkg::CAT_ASYNC]);
    end
  end

  // ---------------------------------------------------------------
  // Output shaping
  // ---------------------------------------------------------------
  hir_pkg::hir_state_e state;
  hir_pkg::hir_state_e next_state;
  logic [31:0] cnt;
  logic [31:0] next_cnt;
  logic [47:0] pulse_prod;
  logic [31:0] pulse_cycles;
  logic [31:0] space_cycles;
  logic        pending;
  logic        new_en;
  logic        armed;
  logic        irq_act;
  logic        next_act;
  logic        trig_pulse;

  // The divide by 65536 trades exact scaling for a shift; FFFFh maps to the full 1 ms.
  assign pulse_prod   = (48'(pulse_q[hir_pkg::PS_WIDTH_LSB +: hir_pkg::PS_WIDTH_W]) + 48'h1)
                        * 48'(PULSE_MAX_CYC);
  assign pulse_cycles = (pulse_prod[47:16] == 32'h0) ? 32'h1 : pulse_prod[47:16];
  assign space_cycles = 32'(pulse_q[hir_pkg::PS_SPACE_LSB +: hir_pkg::PS_SPACE_W])
                        * 32'(SPACE_UNIT_CYC);
  assign pending      = mode_q[hir_pkg::MODE_MASTER] && (|(status & enable));
  assign new_en       = mode_q[hir_pkg::MODE_MASTER] && (|(set_vec & ~status & enable));
  assign trig_pulse   = mode_q[hir_pkg::MODE_TRIG];

  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    next_act   = irq_act;
    unique case (state)
      hir_pkg::ST_IDLE: begin
        if (trig_pulse) begin
          next_act = 1'b0;
          if (armed && pending) begin
            next_state = hir_pkg::ST_PULSE;
            next_cnt   = pulse_cycles - 32'h1;
            next_act   = 1'b1;
          end
        end else if (irq_act && !pending && (space_cycles != 32'h0)) begin
          next_state = hir_pkg::ST_SPACE;
          next_cnt   = space_cycles - 32'h1;
          next_act   = 1'b0;
        end else begin
          next_act = pending;
        end
      end
      hir_pkg::ST_PULSE: begin
        // Status clears are ignored here so the pulse always runs out.
        next_act = 1'b1;
        if (cnt == 32'h0) begin
          next_act   = 1'b0;
          next_state = (space_cycles != 32'h0) ? hir_pkg::ST_SPACE : hir_pkg::ST_IDLE;
          next_cnt   = (space_cycles != 32'h0) ? space_cycles - 32'h1 : 32'h0;
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
      hir_pkg::ST_SPACE: begin
        next_act = 1'b0;
        if (cnt == 32'h0) begin
          next_state = hir_pkg::ST_IDLE;
        end else begin
          next_cnt = cnt - 32'h1;
        end
      end
    endcase
  end

  // This clock is always running, so suspend does not stall interrupt delivery.
  always_ff @(posedge clock) begin
    if (rst) begin
      state   <= hir_pkg::ST_IDLE;
      cnt     <= 32'h0;
      irq_act <= 1'b0;
      irq     <= 1'b1;
    end else if (ce) begin
      state   <= next_state;
      cnt     <= next_cnt;
      irq_act <= next_act;
      irq     <= mode_q[hir_pkg::MODE_POL] ? next_act : ~next_act;
    end
  end

  // Armed records that a new enabled event arrived or no enabled status was pending since the last pulse.
  always_ff @(posedge clock) begin
    if (rst) begin
      armed <= 1'b0;
    end else if (ce) begin
      if (state == hir_pkg::ST_IDLE && next_state == hir_pkg::ST_PULSE) begin
        armed <= new_en;
      end else if (new_en || !pending) begin
        armed <= armed | new_en | !pending;
      end
    end
  end

  // ---------------------------------------------------------------
  // Read port
  // ---------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (rst) begin
      reg_rdata <= 32'h0;
    end else if (ce && reg_rd) begin
      reg_rdata <= 32'h0;
      if (reg_addr == hir_pkg::OFS_MODE) reg_rdata <= mode_q;
      if (reg_addr == hir_pkg::OFS_STATUS) reg_rdata <= 32'(status);
      if (reg_addr == hir_pkg::OFS_ENABLE) reg_rdata <= 32'(enable);
      if (reg_addr == hir_pkg::OFS_PULSE) reg_rdata <= pulse_q;
      if (reg_addr == hir_pkg::OFS_TMO) reg_rdata <= tmo_q;
      for (int c = 0; c < hir_pkg::CAT_N; c++) begin
        if (reg_addr == 8'(hir_pkg::OFS_DONE + 4 * c)) reg_rdata <= 32'(done_map[c]);
        if (reg_addr == 8'(hir_pkg::OFS_ANDM + 4 * c)) reg_rdata <= 32'(and_mask[c]);
        if (reg_addr == 8'(hir_pkg::OFS_ORM + 4 * c)) reg_rdata <= 32'(or_mask[c]);
        if (reg_addr == 8'(hir_pkg::OFS_VALID + 4 * c)) reg_rdata <= 32'(valid[c]);
      end
    end
  end

  // ---------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------
  a_rise_needs_pending: assert property (@(posedge clock) disable iff (rst)
    $rose(irq_act) |-> $past(pending))
    else $error("Interrupt rose without an enabled pending event");

  a_level_follows: assert property (@(posedge clock) disable iff (rst)
    ce && state == hir_pkg::ST_IDLE && !trig_pulse && pending |=> irq_act)
    else $error("Level output dropped while enabled status is set");

  a_polarity_map: assert property (@(posedge clock) disable iff (rst)
    ce |=> irq == ($past(mode_q[hir_pkg::MODE_POL]) ? irq_act : !irq_act))
    else $error("Output polarity does not match polarity select");

  a_reset_default: assert property (@(posedge clock)
    rst |=> irq && !mode_q[hir_pkg::MODE_TRIG] && !mode_q[hir_pkg::MODE_POL])
    else $error("Reset did not give level, active-low, inactive output");

  a_pulse_length: assert property (@(posedge clock) disable iff (rst)
    state == hir_pkg::ST_PULSE && $past(state) != hir_pkg::ST_PULSE
    |-> cnt == $past(pulse_cycles) - 32'h1)
    else $error("Pulse started with wrong length");

  a_pulse_full: assert property (@(posedge clock) disable iff (rst)
    ce && state == hir_pkg::ST_PULSE && cnt != 32'h0 |=> state == hir_pkg::ST_PULSE && irq_act)
    else $error("Pulse was cut short");

  a_space_quiet: assert property (@(posedge clock) disable iff (rst)
    state == hir_pkg::ST_SPACE |-> !irq_act)
    else $error("Output active during spacing delay");

  a_w1c_clear: assert property (@(posedge clock) disable iff (rst)
    ce && wr_status |=> (status & $past(reg_wdata[STS_W-1:0]) & ~$past(set_vec)) == '0)
    else $error("Write of one did not clear status");

  a_event_sets: assert property (@(posedge clock) disable iff (rst)
    ce && (|set_vec) |=> (status & $past(set_vec)) == $past(set_vec))
    else $error("Event did not set its status bit");

  a_async_hold: assert property (@(posedge clock) disable iff (rst)
    ce && tmo_en && !tmo_expire && !evt[hir_pkg::STS_ASYNC] && !status[hir_pkg::STS_ASYNC]
    |=> !status[hir_pkg::STS_ASYNC])
    else $error("Async completion raised before timeout");

  a_valid_clear: assert property (@(posedge clock) disable iff (rst)
    ce && (|done_set_iso) |=> (valid[hir_pkg::CAT_ISO] & $past(done_set_iso)) == '0)
    else $error("Valid flag kept after descriptor done");
endmodule

// ---- verif/hir_host_model.sv ----
// Host processor interrupt input: measures how long irq stays active.
// Assumes irq is synchronous to clock; pol selects the sensed active level.
module hir_host_model (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        pol,
  input  wire logic        irq,
  output logic             active,
  output logic [15:0]      width
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] run;
  // The host must sense the same level that software programmed.
  assign active = (irq == pol);
  always_ff @(posedge clock) begin
    if (rst) begin
      run   <= 16'h0000;
      width <= 16'h0000;
    end else if (active) begin
      run <= run + 16'h0001;
    end else begin
      if (run != 16'h0000) begin
        width <= run;
      end
      run <= 16'h0000;
    end
  end
endmodule

// ---- verif/hir_irq_gen_tb.sv ----
// Self-checking bench for hir_irq_gen with a host interrupt input model.
// Assumes the register map and pulse timing of hir_pkg with shortened spacing and timeout units, 25 MHz clock.
module hir_irq_gen_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clock, rst, reg_wr, reg_rd, dma_done, main_clk_stopped, irq, pol, active;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata, reg_rdata, d;
  logic [15:0] evt, width;
  logic [31:0] done_iso, done_int, done_async;
  int          mismatches, cmp_count, cycles, k, j, code;
  hir_irq_gen #(.SPACE_UNIT_CYC(2), .TMO_UNIT_CYC(50)) dut_u (
    .clock(clock), .rst(rst), .ce(1'b1), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .evt(evt),
    .dma_done(dma_done), .main_clk_stopped(main_clk_stopped), .done_set_iso(done_iso),
    .done_set_int(done_int), .done_set_async(done_async), .irq(irq));
  hir_host_model host_u (.clock(clock), .rst(rst), .pol(pol), .irq(irq),
    .active(active), .width(width));
  always #20 clock = ~clock;
  // Pulse length expected for a width code.
  function automatic int pw(input int c);
    int w;
    w = ((c + 1) * hir_pkg::PULSE_MAX_CYC) >>> 16;
    return (w < 1) ? 1 : w;
  endfunction
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    reg_addr  = a;
    reg_wdata = v;
    reg_wr    = 1'b1;
    tick(1);
    reg_wr = 1'b0;
    // One idle cycle between accesses, so a strobe is never set twice in one step.
    tick(1);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] v);
    reg_addr = a;
    reg_rd   = 1'b1;
    tick(1);
    reg_rd = 1'b0;
    v      = reg_rdata;
    tick(1);
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic pulse_evt(input int b);
    evt = 16'h0001 << b;
    tick(1);
    evt = 16'h0000;
    tick(2);
  endtask
  task automatic report_and_stop();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  // Cuts a hang short; the tests need a few hundred cycles at most.
  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      mismatches++;
      report_and_stop();
    end
  end
  initial begin
    {clock, reg_wr, reg_rd, dma_done, main_clk_stopped, pol} = 6'b000000;
    {reg_addr, reg_wdata, evt, done_iso, done_int, done_async} = '0;
    rst = 1'b1;
    void'($urandom(32'h98019451));
    tick(5);
    rst = 1'b0;
    rd(hir_pkg::OFS_MODE, d);
    chk("mode", 32'h0000_0000, d);
    rd(hir_pkg::OFS_PULSE, d);
    chk("pulse", 32'h0000_0021, d);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    k = $urandom % 3;
    wr(hir_pkg::OFS_MODE, 32'h0000_0001);
    pulse_evt(k);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h1 << k, d);
    wr(hir_pkg::OFS_STATUS, 32'h0000_0000);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h1 << k, d);
    wr(hir_pkg::OFS_STATUS, 32'h1 << k);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h0000_0000, d);
    wr(hir_pkg::OFS_ENABLE, 32'h1 << k);
    pulse_evt(k);
    chk("active", 32'h0000_0001, {31'h0, active});
    pulse_evt(k);
    tick(3);
    chk("active", 32'h0000_0001, {31'h0, active});
    wr(hir_pkg::OFS_STATUS, 32'h1 << k);
    tick(2);
    chk("active", 32'h0000_0000, {31'h0, active});
    wr(hir_pkg::OFS_MODE, 32'h0000_0000);
    pulse_evt(k);
    chk("active", 32'h0000_0000, {31'h0, active});
    wr(hir_pkg::OFS_STATUS, 32'h1 << k);
    wr(hir_pkg::OFS_MODE, 32'h0000_0005);
    pol = 1'b1;
    tick(2);
    chk("irq", 32'h0000_0000, {31'h0, irq});
    pulse_evt(k);
    chk("irq", 32'h0000_0001, {31'h0, irq});
    wr(hir_pkg::OFS_STATUS, 32'h1 << k);
    pol  = 1'b0;
    code = $urandom % 200;
    wr(hir_pkg::OFS_PULSE, code);
    wr(hir_pkg::OFS_MODE, 32'h0000_0003);
    pulse_evt(k);
    tick(1);
    wr(hir_pkg::OFS_STATUS, 32'h1 << k);
    tick(pw(code) + 4);
    chk("width", pw(code), {16'h0, width});
    dma_done = 1'b1;
    main_clk_stopped = 1'b1;
    tick(1);
    {dma_done, main_clk_stopped} = 2'b00;
    tick(2);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h0000_0018, d);
    wr(hir_pkg::OFS_STATUS, 32'h0000_0018);
    j = 8 + $urandom % 24;
    wr(hir_pkg::OFS_ORM, 32'h1 << j);
    wr(8'(hir_pkg::OFS_ANDM + 8'h04), 32'h0000_0016);
    wr(hir_pkg::OFS_VALID, (32'h1 << j) | 32'h0000_0001);
    done_iso = 32'h1 << j;
    tick(1);
    done_iso = 32'h0000_0000;
    tick(3);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h0000_0080, d);
    rd(hir_pkg::OFS_DONE, d);
    chk("done", 32'h1 << j, d);
    rd(hir_pkg::OFS_VALID, d);
    chk("valid", 32'h0000_0001, d);
    wr(hir_pkg::OFS_STATUS, 32'h0000_0080);
    {done_int, done_iso} = {32'h0000_0006, 32'h0000_0010};
    tick(1);
    {done_int, done_iso} = '0;
    tick(3);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h0000_0000, d);
    done_int = 32'h0000_0010;
    tick(1);
    done_int = 32'h0000_0000;
    tick(3);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h0000_0100, d);
    // Async completion is held back until the interval timer expires.
    wr(hir_pkg::OFS_STATUS, 32'h0000_0100);
    wr(8'(hir_pkg::OFS_ORM + 8'h08), 32'h0000_0001);
    wr(hir_pkg::OFS_TMO, 32'h8000_0002);
    done_async = 32'h0000_0001;
    tick(1);
    done_async = 32'h0000_0000;
    tick(20);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h0000_0000, d);
    tick(100);
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h0000_0200, d);
    // Level mode with a spacing gap of 10 units after the output drops.
    wr(hir_pkg::OFS_STATUS, 32'h0000_0200);
    wr(hir_pkg::OFS_PULSE, 32'h0A00_0000);
    wr(hir_pkg::OFS_MODE, 32'h0000_0001);
    pulse_evt(k);
    chk("active", 32'h0000_0001, {31'h0, active});
    wr(hir_pkg::OFS_STATUS, 32'h1 << k);
    pulse_evt(k);
    tick(8);
    chk("active", 32'h0000_0000, {31'h0, active});
    rd(hir_pkg::OFS_STATUS, d);
    chk("status", 32'h1 << k, d);
    tick(14);
    chk("active", 32'h0000_0001, {31'h0, active});
    report_and_stop();
  end
endmodule
